// [design/ipvec_core.sv]
// interrupt priority and vectoring controller of the on-chip core
// Notes on behaviour
// - sources sit in six groups; group number is polling position halved.
// - every group takes one of four levels, shared by its sources.
// - group level is high-register bit over low-register bit; 11 highest.
// - equal-level requests are taken in the fixed polling order.
// - each source supplies its own fixed vector address.
// - a source with its enable clear never vectors.
// - external flags 0 to 5 set by hardware, cleared on vectoring.
// - transfer-busy and one-second events, each flagged and enabled, feed line 6.
// - low register bits 0-5 hold group levels; watchdog bit has no effect.
// - secondary flags clear only by written zeros; ones are ignored.
// - lines 2 and 3 have selectable edge polarity; a clear select bit, the reset value, picks falling.
// - lines 4 to 6 are rising edge; lines 5 and 6 are inverted first.
`timescale 1ns/1ps
module ipvec_core
    import ipvec_pkg::*;
(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  SYS_RST,
    // register port
    input  wire logic [3:0]            REG_SEL,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire logic [7:0]            REG_WDATA,
    output logic [7:0]                 REG_RDATA,
    // interrupt sources
    input  wire ipvec_pkg::ipvec_src_t SRC,
    input  wire ipvec_pkg::ipvec_aux_t AUX_EVT,
    // core handshake
    output ipvec_pkg::ipvec_req_t      IRQ,
    input  wire logic                  IRQ_ACK,
    input  wire logic                  IRQ_RETI
);

    logic [7:0]             lvl_lo_q, lvl_hi_q, en_a_q, en_b_q;
    logic [7:0]             aux_q, aux_d, aen_q, ctrl_q, rdata_q;
    logic [NUM_SRC-1:0]     flag_q, flag_d;
    logic [NUM_LVL-1:0]     isr_q, isr_d;
    logic [4:0]             line_q;
    logic                   win_q;
    logic [3:0]             idx_q;
    logic [1:0]             lvl_q;
    logic [15:0]            vec_q;

    wire                    wr_lvl_lo  = REG_WR && REG_SEL == R_LVL_LO;
    wire                    wr_lvl_hi  = REG_WR && REG_SEL == R_LVL_HI;
    wire                    wr_en_a    = REG_WR && REG_SEL == R_EN_A;
    wire                    wr_en_b    = REG_WR && REG_SEL == R_EN_B;
    wire                    wr_flag_a  = REG_WR && REG_SEL == R_FLAG_A;
    wire                    wr_flag_b  = REG_WR && REG_SEL == R_FLAG_B;
    wire                    wr_aux     = REG_WR && REG_SEL == R_AUX_FLG;
    wire                    wr_aen     = REG_WR && REG_SEL == R_AUX_EN;
    wire                    wr_ctrl    = REG_WR && REG_SEL == R_CTRL;
    wire                    take       = IRQ_ACK && win_q;

    // secondary events gated by enables; both fw collisions share one, as do both pll edges
    wire [7:0]              aux_set    = {AUX_EVT.pll_fall, AUX_EVT.pll_rise, 2'b00,
                                          AUX_EVT.fwcol0, AUX_EVT.fwcol1,
                                          AUX_EVT.one_sec, AUX_EVT.transfer_busy_event};
    wire                    fw_act     = en_fw(aux_q, aen_q);
    wire                    pll_act    = (aux_q[B_AUX_PLLR] | aux_q[B_AUX_PLLF])
                                         & aen_q[B_AEN_PLL];
    wire                    x6_act     = (aux_q[B_AUX_XFER] & aen_q[B_AEN_XFER])
                                         | (aux_q[B_AUX_RTC] & aen_q[B_AEN_RTC]);

    // raw lines of external 2..6: 2 and 6 are active low at their source
    wire [4:0]              line_raw   = {~x6_act, SRC.ext5_line, pll_act,
                                          SRC.ext3_line, ~fw_act};
    // lines 5 and 6 inverted, all of 4..6 then rising edge
    wire [4:0]              line_int   = {~line_raw[4], ~line_raw[3], line_raw[2:0]};
    wire [4:0]              rise       = line_int & ~line_q;
    wire [4:0]              fall       = ~line_int & line_q;
    // polarity select of lines 2 and 3, 0 = falling
    wire                    ext2_edge  = ctrl_q[B_EXT2_POL] ? rise[0] : fall[0];
    wire                    ext3_edge  = ctrl_q[B_EXT3_POL] ? rise[1] : fall[1];

    wire [NUM_SRC-1:0]      set_evt    = sort_src({rise[4], rise[3], rise[2], ext3_edge,
                                                   ext2_edge, 1'b0, 1'b0,
                                                   SRC.tmr1_ovf, SRC.tmr0_ovf,
                                                   SRC.ext1_evt, SRC.ext0_evt});
    // enable A holds ext0, tmr0, ext1, tmr1, ser0 in bits 0..4
    wire [NUM_SRC-1:0]      en_vec     = sort_src({en_b_q[5:1], en_b_q[0], en_a_q[4], en_a_q[3],
                                                   en_a_q[1], en_a_q[2], en_a_q[0]});
    wire [NUM_SRC-1:0]      lvl_src    = set_lvl_src(SRC.ser0_req, SRC.ser1_req);
    // enable and global enable gate every request
    wire [NUM_SRC-1:0]      pend       = (flag_d | lvl_src) & en_vec
                                         & {NUM_SRC{en_a_q[B_GLOBAL_EN]}};

    // level code per group, watchdog bit excluded
    logic [NUM_GRP-1:0][1:0] grp_lvl;
    always_comb
    begin
        for (int g = 0; g < NUM_GRP; g++)
            grp_lvl[g] = {lvl_hi_q[g], lvl_lo_q[g]};
    end

    // reorders {ext6,ext5,ext4,ext3,ext2,ser1,ser0,tmr1,tmr0,ext1,ext0} to polling order
    function automatic logic [NUM_SRC-1:0] sort_src(input logic [NUM_SRC-1:0] v);
        logic [NUM_SRC-1:0] r;
        r = '0;
        r[S_EXT0] = v[0];
        r[S_EXT1] = v[1];
        r[S_TMR0] = v[2];
        r[S_TMR1] = v[3];
        r[S_SER0] = v[4];
        r[S_SER1] = v[5];
        r[S_EXT2] = v[6];
        r[S_EXT3] = v[7];
        r[S_EXT4] = v[8];
        r[S_EXT5] = v[9];
        r[S_EXT6] = v[10];
        sort_src = r;
    endfunction

    function automatic logic [NUM_SRC-1:0] set_lvl_src(input logic s0, input logic s1);
        logic [NUM_SRC-1:0] r;
        r = '0;
        r[S_SER0] = s0;
        r[S_SER1] = s1;
        set_lvl_src = r;
    endfunction

    function automatic logic en_fw(input logic [7:0] f, input logic [7:0] e);
        en_fw = (f[B_AUX_FWCOL0] | f[B_AUX_FWCOL1]) & e[B_AEN_FWCOL];
    endfunction

    // hardware set wins over clear by vectoring or software
    always_comb
    begin
        flag_d = flag_q;
        if (wr_flag_a)
        begin
            flag_d[S_EXT0] = REG_WDATA[0];
            flag_d[S_EXT1] = REG_WDATA[1];
            flag_d[S_TMR0] = REG_WDATA[2];
            flag_d[S_TMR1] = REG_WDATA[3];
        end
        if (wr_flag_b)
        begin
            flag_d[S_EXT2] = REG_WDATA[1];
            flag_d[S_EXT3] = REG_WDATA[2];
            flag_d[S_EXT4] = REG_WDATA[3];
            flag_d[S_EXT5] = REG_WDATA[4];
            flag_d[S_EXT6] = REG_WDATA[5];
        end
        if (take && AUTO_CLR[idx_q])
            flag_d[idx_q] = 1'b0;
        flag_d = flag_d | set_evt;
    end

    // write-zero clear, ones ignored, new events win
    always_comb
    begin
        aux_d = aux_q;
        if (wr_aux)
            aux_d = aux_q & REG_WDATA;
        aux_d = (aux_d | aux_set) & AUX_MASK;
    end

    // in-service levels: return drops the top one, vectoring adds one
    always_comb
    begin
        isr_d = isr_q;
        if (IRQ_RETI)
        begin
            for (int l = 0; l < NUM_LVL; l++)
            begin
                if (isr_q[l])
                    isr_d = isr_q & ~(4'h1 << l);
            end
        end
        if (take)
            isr_d[lvl_q] = 1'b1;
    end

    logic       arb_win;
    logic [3:0] arb_idx;
    logic [1:0] arb_lvl;

    ipvec_arb #(
        .NSRC    (NUM_SRC)
    ) u_arb (
        .pend    (pend),
        .grp_lvl (grp_lvl),
        .in_svc  (isr_d),
        .win     (arb_win),
        .win_idx (arb_idx),
        .win_lvl (arb_lvl)
    );

    logic [7:0] rd_mux;
    always_comb
    begin
        case (REG_SEL)
            R_LVL_LO:  rd_mux = lvl_lo_q;
            R_LVL_HI:  rd_mux = lvl_hi_q;
            R_EN_A:    rd_mux = en_a_q;
            R_EN_B:    rd_mux = en_b_q;
            R_FLAG_A:  rd_mux = {4'h0, flag_q[S_TMR1], flag_q[S_TMR0],
                                flag_q[S_EXT1], flag_q[S_EXT0]};
            R_FLAG_B:  rd_mux = {2'h0, flag_q[S_EXT6], flag_q[S_EXT5],
                                flag_q[S_EXT4], flag_q[S_EXT3], flag_q[S_EXT2], 1'b0};
            R_AUX_FLG: rd_mux = aux_q;
            R_AUX_EN:  rd_mux = aen_q;
            R_CTRL:    rd_mux = ctrl_q;
            R_STATUS:  rd_mux = {4'h0, isr_q};
            default:   rd_mux = RST_BYTE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            lvl_lo_q <= RST_BYTE;
            lvl_hi_q <= RST_BYTE;
            en_a_q   <= RST_BYTE;
            en_b_q   <= RST_BYTE;
            aen_q    <= RST_BYTE;
            ctrl_q   <= RST_BYTE;
            aux_q    <= RST_BYTE;
            rdata_q  <= RST_BYTE;
        end
        else
        begin
            if (wr_lvl_lo) lvl_lo_q <= REG_WDATA & LVL_LO_MASK;
            if (wr_lvl_hi) lvl_hi_q <= REG_WDATA & LVL_HI_MASK;
            if (wr_en_a)   en_a_q   <= REG_WDATA & EN_A_MASK;
            if (wr_en_b)   en_b_q   <= REG_WDATA & EN_B_MASK;
            if (wr_aen)    aen_q    <= REG_WDATA & AEN_MASK;
            if (wr_ctrl)   ctrl_q   <= REG_WDATA & CTRL_MASK;
            aux_q <= aux_d;
            if (REG_RD)    rdata_q  <= rd_mux;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            flag_q <= '0;
            isr_q  <= '0;
            // edge history starts at the present line level: no false edge on release
            line_q <= line_int;
            win_q  <= 1'b0;
            idx_q  <= 4'h0;
            lvl_q  <= 2'h0;
            vec_q  <= 16'h0000;
        end
        else
        begin
            flag_q <= flag_d;
            isr_q  <= isr_d;
            line_q <= line_int;
            win_q  <= arb_win;
            idx_q  <= arb_idx;
            lvl_q  <= arb_lvl;
            vec_q  <= VEC_TABLE[arb_idx];
        end
    end

    assign REG_RDATA = rdata_q;
    assign IRQ.req   = win_q;
    assign IRQ.level = lvl_q;
    assign IRQ.addr  = vec_q;

endmodule

// [shared/ipvec_pkg.sv]
// shared constants and types of the interrupt priority and vectoring block
package ipvec_pkg;

    // source indices, listed in the fixed polling order
    localparam int NUM_SRC  = 11;
    localparam int NUM_GRP  = 6;
    localparam int NUM_LVL  = 4;
    localparam int S_EXT0   = 0;
    localparam int S_SER1   = 1;
    localparam int S_TMR0   = 2;
    localparam int S_EXT2   = 3;
    localparam int S_EXT1   = 4;
    localparam int S_EXT3   = 5;
    localparam int S_TMR1   = 6;
    localparam int S_EXT4   = 7;
    localparam int S_SER0   = 8;
    localparam int S_EXT5   = 9;
    localparam int S_EXT6   = 10;

    // vector address of each source, index = polling position
    localparam logic [NUM_SRC-1:0][15:0] VEC_TABLE = {
        16'h006b, 16'h0063, 16'h0023, 16'h005b, 16'h001b, 16'h0053,
        16'h0013, 16'h004b, 16'h000b, 16'h0083, 16'h0003};

    // flags cleared by hardware when the core takes the vector
    localparam logic [NUM_SRC-1:0] AUTO_CLR = 11'h2fd;

    // register selects
    localparam logic [3:0] R_LVL_LO  = 4'h0;
    localparam logic [3:0] R_LVL_HI  = 4'h1;
    localparam logic [3:0] R_EN_A    = 4'h2;
    localparam logic [3:0] R_EN_B    = 4'h3;
    localparam logic [3:0] R_FLAG_A  = 4'h4;
    localparam logic [3:0] R_FLAG_B  = 4'h5;
    localparam logic [3:0] R_AUX_FLG = 4'h6;
    localparam logic [3:0] R_AUX_EN  = 4'h7;
    localparam logic [3:0] R_CTRL    = 4'h8;
    localparam logic [3:0] R_STATUS  = 4'h9;

    // field positions
    localparam int B_GLOBAL_EN  = 7;
    localparam int B_WDT_STATUS = 6;
    localparam int B_EXT2_POL   = 5;
    localparam int B_EXT3_POL   = 6;
    localparam int B_AUX_XFER   = 0;
    localparam int B_AUX_RTC    = 1;
    localparam int B_AUX_FWCOL1 = 2;
    localparam int B_AUX_FWCOL0 = 3;
    localparam int B_AUX_PLLR   = 6;
    localparam int B_AUX_PLLF   = 7;
    localparam int B_AEN_XFER   = 0;
    localparam int B_AEN_RTC    = 1;
    localparam int B_AEN_FWCOL  = 4;
    localparam int B_AEN_PLL    = 5;

    // writable bit masks and reset values
    localparam logic [7:0] LVL_LO_MASK = 8'h7f;
    localparam logic [7:0] LVL_HI_MASK = 8'h3f;
    localparam logic [7:0] EN_A_MASK   = 8'h9f;
    localparam logic [7:0] EN_B_MASK   = 8'h3f;
    localparam logic [7:0] AUX_MASK    = 8'hcf;
    localparam logic [7:0] AEN_MASK    = 8'h33;
    localparam logic [7:0] CTRL_MASK   = 8'h60;
    localparam logic [7:0] RST_BYTE    = 8'h00;

    // source event pulses and request levels
    typedef struct packed {
        logic ext0_evt;
        logic ext1_evt;
        logic tmr0_ovf;
        logic tmr1_ovf;
        logic ser0_req;
        logic ser1_req;
        logic ext3_line;
        logic ext5_line;
    } ipvec_src_t;

    // events behind the shared external lines 2, 4 and 6
    typedef struct packed {
        logic transfer_busy_event;
        logic one_sec;
        logic fwcol0;
        logic fwcol1;
        logic pll_rise;
        logic pll_fall;
    } ipvec_aux_t;

    // request toward the core
    typedef struct packed {
        logic        req;
        logic [1:0]  level;
        logic [15:0] addr;
    } ipvec_req_t;

    function automatic logic [2:0] src_group(input int idx);
        src_group = 3'(idx / 2);
    endfunction

endpackage

// [design/ipvec_arb.sv]
// priority resolver: picks the winning pending source
`timescale 1ns/1ps
module ipvec_arb
    import ipvec_pkg::*;
#(
    parameter int NSRC = ipvec_pkg::NUM_SRC
)(
    // requests and levels
    input  wire logic [NSRC-1:0]                    pend,
    input  wire logic [ipvec_pkg::NUM_GRP-1:0][1:0] grp_lvl,
    input  wire logic [ipvec_pkg::NUM_LVL-1:0]      in_svc,
    // result
    output logic                                    win,
    output logic [3:0]                              win_idx,
    output logic [1:0]                              win_lvl
);

    logic       svc_any;
    logic [1:0] svc_top;
    logic [2:0] found_lvl;

    always_comb
    begin
        svc_any = |in_svc;
        svc_top = 2'h0;
        for (int l = 0; l < NUM_LVL; l++)
        begin
            if (in_svc[l])
                svc_top = 2'(l);
        end
        win     = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        found_lvl = 3'h0;
        for (int l = NUM_LVL - 1; l >= 0; l--)
        begin
            for (int i = NSRC - 1; i >= 0; i--)
            begin
                if (pend[i] && grp_lvl[src_group(i)] == 2'(l) && !win)
                begin
                    found_lvl = 3'(l) + 3'h1;
                end
            end
            if (found_lvl != 3'h0 && !win)
            begin
                for (int i = NSRC - 1; i >= 0; i--)
                begin
                    if (pend[i] && grp_lvl[src_group(i)] == 2'(l))
                        win_idx = 4'(i);
                end
                win_lvl = 2'(l);
                win = !svc_any || (2'(l) > svc_top);
                found_lvl = 3'h4;
            end
        end
    end

endmodule

// [testbench/ipvec_core_properties.sv]
// port checker of the interrupt vectoring controller
`timescale 1ns/1ps
module ipvec_core_properties
(
    // clock, reset and register port
    input wire logic                  CLK,
    input wire logic                  SYS_RST,
    input wire logic [3:0]            REG_SEL,
    input wire logic                  REG_WR,
    input wire logic                  REG_RD,
    input wire logic [7:0]            REG_WDATA,
    input wire logic [7:0]            REG_RDATA,
    // sources and core handshake
    input wire ipvec_pkg::ipvec_src_t SRC,
    input wire ipvec_pkg::ipvec_aux_t AUX_EVT,
    input wire ipvec_pkg::ipvec_req_t IRQ,
    input wire logic                  IRQ_ACK,
    input wire logic                  IRQ_RETI
);
    import ipvec_pkg::*;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic [7:0] ena_q;
    logic [3:0] svc_q;
    function automatic logic [2:0] grp_of(input logic [15:0] a);
        grp_of = 3'h0;
        for (int i = 0; i < NUM_SRC; i++)
            if (VEC_TABLE[i] == a)
                grp_of = 3'(i / 2);
    endfunction
    wire logic [2:0] g       = grp_of(IRQ.addr);
    wire logic [3:0] svc_top = svc_q[3] ? 4'h8 : svc_q[2] ? 4'h4 : svc_q[1] ? 4'h2 : svc_q & 4'h1;
    // return drops the top level before a new acceptance is added
    wire logic [3:0] svc_d   = (svc_q & ~(IRQ_RETI ? svc_top : 4'h0))
                             | ((IRQ_ACK && IRQ.req) ? (4'h1 << IRQ.level) : 4'h0);
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            lo_q  <= 8'h00;
            hi_q  <= 8'h00;
            ena_q <= 8'h00;
            svc_q <= 4'h0;
        end
        else
        begin
            if (REG_WR && REG_SEL == R_LVL_LO) lo_q <= REG_WDATA;
            if (REG_WR && REG_SEL == R_LVL_HI) hi_q <= REG_WDATA;
            if (REG_WR && REG_SEL == R_EN_A) ena_q <= REG_WDATA;
            svc_q <= svc_d;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_vector_known: assert property (
        IRQ.req |-> IRQ.addr inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
            16'h0083, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b})
        else $error("vector outside table");
    a_group_level: assert property (
        IRQ.req && !$past(REG_WR) && !$past(REG_WR, 2) |-> IRQ.level == {hi_q[g], lo_q[g]})
        else $error("offered level wrong");
    a_global_gate: assert property (
        IRQ.req && !$past(REG_WR) && !$past(REG_WR, 2) |-> ena_q[B_GLOBAL_EN])
        else $error("request while disabled");
    a_ext0_request: assert property (
        SRC.ext0_evt && ena_q[0] && ena_q[B_GLOBAL_EN] && svc_q == 4'h0 && !REG_WR
        |-> ##[1:2] IRQ.req)
        else $error("ext0 not requested");
    a_preempt_higher: assert property (
        IRQ.req && !$past(IRQ_ACK) && !$past(IRQ_RETI) |-> (4'h1 << IRQ.level) > svc_top)
        else $error("offer not above running level");
    a_status_svc: assert property (
        REG_RD && REG_SEL == R_STATUS |=> REG_RDATA == {4'h0, $past(svc_q)})
        else $error("status in-service wrong");
    a_low_readback: assert property (
        REG_RD && REG_SEL == R_LVL_LO |=> REG_RDATA == ($past(lo_q) & LVL_LO_MASK))
        else $error("low level readback wrong");
    a_reset_idle: assert property (
        disable iff (1'b0) SYS_RST |=> !IRQ.req && REG_RDATA == 8'h00)
        else $error("not idle after reset");
    c_preempt: cover property (IRQ_ACK && IRQ.req && svc_q != 4'h0);
    c_ext6_taken: cover property (IRQ_ACK && IRQ.req && IRQ.addr == 16'h006b);
    c_top_level: cover property (IRQ.req && IRQ.level == 2'h3);
endmodule
bind ipvec_core ipvec_core_properties u_props (.CLK(CLK), .SYS_RST(SYS_RST),
    .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .SRC(SRC), .AUX_EVT(AUX_EVT), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK),
    .IRQ_RETI(IRQ_RETI));

// [testbench/ipvec_cpu_model.sv]
// behavioural core that takes vectors and returns from handlers
`timescale 1ns/1ps
module ipvec_cpu_model
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // controller side
    input  wire ipvec_pkg::ipvec_req_t irq,
    output logic                       ack,
    output logic                       reti,
    // bench side
    input  wire logic                  take_en,
    input  wire logic                  ret_go,
    output logic [15:0]                last_addr,
    output logic [1:0]                 last_lvl,
    output int                         taken
);
    import ipvec_pkg::*;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack       <= 1'b0;
            reti      <= 1'b0;
            last_addr <= 16'h0000;
            last_lvl  <= 2'h0;
            taken     <= 0;
        end
        else
        begin
            reti <= ret_go;
            ack  <= take_en && irq.req && !ack;
            if (ack && irq.req)
            begin
                last_addr <= irq.addr;
                last_lvl  <= irq.level;
                taken     <= taken + 1;
            end
        end
    end
endmodule

// [testbench/ipvec_core_tb.sv]
// self-checking bench of the interrupt vectoring controller
`timescale 1ns/1ps
module ipvec_core_tb;
    import ipvec_pkg::*;
    localparam logic [15:0] VEC [11] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013,
        16'h0053, 16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};
    localparam logic [7:0] RB [9] = '{8'h7f, 8'h3f, 8'h9f, 8'h3f, 8'h0f, 8'h3e, 8'h00, 8'h33,
        8'h60};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  sel = 4'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    ipvec_src_t  src = 8'h01;
    ipvec_aux_t  aux = 6'h00;
    ipvec_req_t  irq;
    logic        ack;
    logic        reti;
    logic        take_en = 1'b0;
    logic        ret_go = 1'b0;
    logic [15:0] last_addr;
    logic [1:0]  last_lvl;
    int          taken;
    int          error_cnt = 0;
    int          checked = 0;
    always #2 clk = ~clk;
    ipvec_core u_dut (.CLK(clk), .SYS_RST(rst), .REG_SEL(sel), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .SRC(src), .AUX_EVT(aux), .IRQ(irq),
        .IRQ_ACK(ack), .IRQ_RETI(reti));
    ipvec_cpu_model u_cpu (.clk(clk), .rst(rst), .irq(irq), .ack(ack), .reti(reti),
        .take_en(take_en), .ret_go(ret_go), .last_addr(last_addr), .last_lvl(last_lvl),
        .taken(taken));
    task automatic stop_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        sel <= s;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] s, input logic [7:0] e);
        sel <= s;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic ret();
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic take(input logic [15:0] a, input logic [1:0] l);
        int n;
        n = taken;
        for (int i = 0; i < 50 && taken == n; i++)
            @(posedge clk);
        if (taken == n)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t no vector taken", $time);
            stop_test();
        end
        else
        begin
            chk(last_addr, a);
            chk({14'h0, last_lvl}, {14'h0, l});
        end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 16; i++)
            rdc(4'(i), 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            wr(4'(i), 8'hff);
            rdc(4'(i), RB[i]);
        end
        wr(R_STATUS, 8'hff);
        wr(4'hf, 8'hff);
        rdc(4'hf, 8'h00);
        for (int i = 0; i < 9; i++)
            wr(4'(i), 8'h00);
        rdc(R_STATUS, 8'h00);
        wr(R_EN_A, 8'h80);
        src.ext0_evt <= 1'b1;
        @(posedge clk);
        src.ext0_evt <= 1'b0;
        cyc(4);
        chk(16'(irq.req), 16'h0000);
        rdc(R_FLAG_A, 8'h01);
        wr(R_EN_A, 8'h9f);
        wr(R_EN_B, 8'h3f);
        wr(R_FLAG_A, 8'h0f);
        wr(R_FLAG_B, 8'h3e);
        src.ser0_req <= 1'b1;
        src.ser1_req <= 1'b1;
        take_en <= 1'b1;
        for (int i = 0; i < 11; i++)
        begin
            take(VEC[i], 2'h0);
            src.ser1_req <= src.ser1_req && i != 1;
            src.ser0_req <= src.ser0_req && i != 8;
            if (i == 10)
                wr(R_FLAG_B, 8'h00);
            ret();
        end
        rdc(R_FLAG_A, 8'h00);
        rdc(R_FLAG_B, 8'h00);
        wr(R_LVL_HI, 8'h24);
        wr(R_LVL_LO, 8'h61);
        src.ext0_evt <= 1'b1;
        @(posedge clk);
        src.ext0_evt <= 1'b0;
        take(16'h0003, 2'h1);
        wr(R_FLAG_B, 8'h20);
        take(16'h006b, 2'h3);
        src.ext1_evt <= 1'b1;
        @(posedge clk);
        src.ext1_evt <= 1'b0;
        cyc(4);
        chk(16'(irq.req), 16'h0000);
        rdc(R_STATUS, 8'h0a);
        wr(R_FLAG_B, 8'h00);
        ret();
        take(16'h0013, 2'h2);
        rdc(R_STATUS, 8'h06);
        ret();
        ret();
        wr(R_LVL_HI, 8'h00);
        wr(R_AUX_EN, 8'h01);
        aux.transfer_busy_event <= 1'b1;
        @(posedge clk);
        aux.transfer_busy_event <= 1'b0;
        take(16'h006b, 2'h1);
        rdc(R_AUX_FLG, 8'h01);
        wr(R_AUX_FLG, 8'hfe);
        rdc(R_AUX_FLG, 8'h00);
        wr(R_FLAG_B, 8'h00);
        ret();
        aux.one_sec <= 1'b1;
        @(posedge clk);
        aux.one_sec <= 1'b0;
        cyc(4);
        chk(16'(irq.req), 16'h0000);
        rdc(R_AUX_FLG, 8'h02);
        take_en <= 1'b0;
        src.ext3_line <= 1'b1;
        src.ext5_line <= 1'b0;
        cyc(3);
        rdc(R_FLAG_B, 8'h10);
        src.ext3_line <= 1'b0;
        src.ext5_line <= 1'b1;
        cyc(3);
        rdc(R_FLAG_B, 8'h14);
        wr(R_FLAG_B, 8'h00);
        wr(R_CTRL, 8'h40);
        src.ext3_line <= 1'b1;
        cyc(3);
        rdc(R_FLAG_B, 8'h04);
        wr(R_FLAG_B, 8'h00);
        wr(R_AUX_EN, 8'h30);
        aux.fwcol0 <= 1'b1;
        aux.pll_rise <= 1'b1;
        src.tmr0_ovf <= 1'b1;
        @(posedge clk);
        aux.fwcol0 <= 1'b0;
        aux.pll_rise <= 1'b0;
        src.tmr0_ovf <= 1'b0;
        cyc(3);
        rdc(R_FLAG_B, 8'h0a);
        rdc(R_FLAG_A, 8'h04);
        rdc(R_AUX_FLG, 8'h4a);
        stop_test();
    end
endmodule
